// ===== flash_ctl_pkg.sv
package flash_ctl_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // Command sequence addresses and codes
  localparam logic [18:0] CMD_ADDR_A = 19'h05555;
  localparam logic [18:0] CMD_ADDR_B = 19'h02AAA;
  localparam logic [7:0] CODE_UNLOCK_A = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK_B = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_LOCKOUT = 8'h40;
  localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
  localparam logic [7:0] CODE_ID_EXIT = 8'hF0;

  // Boot block and lockout status location
  localparam logic [18:0] BOOT_BOTTOM_BASE = 19'h00000;
  localparam logic [18:0] BOOT_BOTTOM_LAST = 19'h01FFF;
  localparam logic [18:0] BOOT_TOP_BASE = 19'h7E000;
  localparam logic [18:0] BOOT_TOP_LAST = 19'h7FFFF;
  localparam logic [18:0] LOCK_STAT_BOTTOM = 19'h00002;
  localparam logic [18:0] LOCK_STAT_TOP = 19'h7E002;

  // Sector select addresses, upper seven bits (18:12) of the word address
  localparam logic [18:0] SECT_BOTTOM_BOOT = 19'h01000;
  localparam logic [18:0] SECT_BOTTOM_PAR1 = 19'h02000;
  localparam logic [18:0] SECT_BOTTOM_PAR2 = 19'h03000;
  localparam logic [18:0] SECT_BOTTOM_MAIN = 19'h7F000;
  localparam logic [18:0] SECT_TOP_BOOT = 19'h7F000;
  localparam logic [18:0] SECT_TOP_PAR1 = 19'h7D000;
  localparam logic [18:0] SECT_TOP_PAR2 = 19'h7C000;
  localparam logic [18:0] SECT_TOP_MAIN = 19'h7B000;

  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int LOCK_BIT = 0;

  // Bus timing at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_NS = 60;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NOISE_NS = 15;
  localparam int NOISE_CYC = (NOISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = 1;
  localparam int POWER_ON_MS = 10;
  localparam int POWER_ON_CYC = POWER_ON_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POLL_LIMIT = 1000000;

  typedef enum logic [2:0] {
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_CHIP_ERASE,
    OP_LOCKOUT,
    OP_ID_ENTRY,
    OP_ID_EXIT,
    OP_ID_EXIT_SHORT,
    OP_READ
  } op_type;

  typedef struct packed {
    op_type op;
    logic [18:0] addr;
    logic [15:0] data;
    logic override;
  } req_type;

  typedef struct packed {
    logic [18:0] addr;
    logic [15:0] dout;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
  } pins_type;

endpackage

// ===== flash_bus_cycle.sv
`timescale 1ns/100ps
`default_nettype none
// One write or read cycle on the asynchronous flash bus.
module flash_bus_cycle #(
  parameter int STROBE_CYC = flash_ctl_pkg::STROBE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic write,
  input wire logic [18:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in,
  output logic done,
  output logic [15:0] rdata,
  output flash_ctl_pkg::pins_type pins
);
  typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} cyc_state_type;
  typedef struct packed {
    cyc_state_type st;
    logic [7:0] cnt;
    logic wr;
    logic [15:0] rd;
    flash_ctl_pkg::pins_type p;
  } cyc_type;
  cyc_type s_reg;
  cyc_type s_next;

  always_comb
  begin
    s_next = s_reg;
    done = 1'b0;
    unique case (s_reg.st)
      IDLE:
      begin
        if (start)
        begin
          s_next.st = SETUP;
          s_next.wr = write;
          s_next.p.addr = addr;
          s_next.p.dout = wdata;
          // Drive data only on writes; OE held high then
          s_next.p.dq_oe_n = ~write;
          s_next.p.ce_n = 1'b0;
        end
      end
      SETUP:
      begin
        s_next.st = STROBE;
        s_next.cnt = 8'(STROBE_CYC);
        if (s_reg.wr)
          s_next.p.we_n = 1'b0;
        else
          s_next.p.oe_n = 1'b0;
      end
      STROBE:
      begin
        if (s_reg.cnt > 8'h01)
          s_next.cnt = s_reg.cnt - 8'h01;
        else
        begin
          s_next.st = HOLD;
          s_next.rd = dq_in;
          s_next.p.we_n = 1'b1;
          s_next.p.oe_n = 1'b1;
        end
      end
      HOLD:
      begin
        // Data held one cycle past rising edge
        s_next.st = IDLE;
        s_next.p.ce_n = 1'b1;
        s_next.p.dq_oe_n = 1'b1;
        done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.st <= IDLE;
      s_reg.p.ce_n <= 1'b1;
      s_reg.p.oe_n <= 1'b1;
      s_reg.p.we_n <= 1'b1;
      s_reg.p.dq_oe_n <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign rdata = s_reg.rd;
  assign pins = s_reg.p;
endmodule
`default_nettype wire

// ===== flash_host_ctl.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Program: AA, 55, A0, then address/data
// - Lockout: six writes ending 40
// - Override level bypasses lockout
// - ID entry 90; exit F0 forms
// - Address on fall, data on rise
module flash_host_ctl #(
  parameter int POWER_ON_CYC = flash_ctl_pkg::POWER_ON_CYC,
  parameter int POLL_LIMIT = flash_ctl_pkg::POLL_LIMIT,
  parameter bit TOP_BOOT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire flash_ctl_pkg::req_type req,
  output logic resp_valid,
  output logic [15:0] resp_data,
  output logic resp_error,
  output logic resp_locked,
  output logic [18:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic flash_override,
  input wire logic flash_ready_n_low
);
  typedef enum logic [2:0] {WAIT_PWR, IDLE, WRITE, POLL, REPORT} st_type;
  typedef struct packed {
    st_type st;
    logic [23:0] pwr_cnt;
    logic [2:0] step;
    logic [2:0] nsteps;
    flash_ctl_pkg::req_type r;
    logic [15:0] last_rd;
    logic have_last;
    logic [19:0] poll_cnt;
    logic [15:0] data;
    logic err;
    logic locked;
    logic valid;
    logic go;
    logic wr;
    logic [18:0] a;
    logic [15:0] d;
  } ctl_type;
  ctl_type s_reg;
  ctl_type s_next;

  logic cyc_done;
  logic [15:0] cyc_rdata;
  flash_ctl_pkg::pins_type pins;

  flash_bus_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .start(s_reg.go),
    .write(s_reg.wr),
    .addr(s_reg.a),
    .wdata(s_reg.d),
    .dq_in(flash_dq_in),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(pins)
  );

  // Address and data of one step of a command sequence
  function automatic logic [34:0] step_word(flash_ctl_pkg::req_type r, logic [2:0] i);
    logic [18:0] a;
    logic [7:0] d;
    a = flash_ctl_pkg::CMD_ADDR_A;
    d = flash_ctl_pkg::CODE_UNLOCK_A;
    if (i == 3'd1 || i == 3'd4)
    begin
      a = flash_ctl_pkg::CMD_ADDR_B;
      d = flash_ctl_pkg::CODE_UNLOCK_B;
    end
    else if (i == 3'd2)
    begin
      unique case (r.op)
        flash_ctl_pkg::OP_PROGRAM: d = flash_ctl_pkg::CODE_PROGRAM;
        flash_ctl_pkg::OP_ID_ENTRY: d = flash_ctl_pkg::CODE_ID_ENTRY;
        flash_ctl_pkg::OP_ID_EXIT: d = flash_ctl_pkg::CODE_ID_EXIT;
        default: d = flash_ctl_pkg::CODE_ERASE_SETUP;
      endcase
    end
    else if (i == 3'd3 && r.op == flash_ctl_pkg::OP_PROGRAM)
      return {r.addr, r.data};
    else if (i == 3'd5)
    begin
      unique case (r.op)
        flash_ctl_pkg::OP_SECTOR_ERASE:
        begin
          a = r.addr;
          d = flash_ctl_pkg::CODE_SECTOR_ERASE;
        end
        flash_ctl_pkg::OP_LOCKOUT: d = flash_ctl_pkg::CODE_LOCKOUT;
        default: d = flash_ctl_pkg::CODE_CHIP_ERASE;
      endcase
    end
    if (r.op == flash_ctl_pkg::OP_ID_EXIT_SHORT)
    begin
      a = r.addr;
      d = flash_ctl_pkg::CODE_ID_EXIT;
    end
    // upper data byte is don't care, sent as zero
    return {a, 8'h00, d};
  endfunction

  function automatic logic [2:0] seq_len(flash_ctl_pkg::op_type op);
    unique case (op)
      flash_ctl_pkg::OP_PROGRAM: return 3'd4;
      flash_ctl_pkg::OP_ID_ENTRY, flash_ctl_pkg::OP_ID_EXIT: return 3'd3;
      flash_ctl_pkg::OP_ID_EXIT_SHORT, flash_ctl_pkg::OP_READ: return 3'd1;
      default: return 3'd6;
    endcase
  endfunction

  function automatic logic is_boot(logic [18:0] a);
    if (TOP_BOOT)
      return a >= flash_ctl_pkg::BOOT_TOP_BASE;
    return a <= flash_ctl_pkg::BOOT_BOTTOM_LAST;
  endfunction

  logic [34:0] sw;
  always_comb
  begin
    s_next = s_reg;
    s_next.go = 1'b0;
    s_next.valid = 1'b0;
    sw = step_word(s_reg.r, s_reg.step);
    unique case (s_reg.st)
      WAIT_PWR:
      begin
        if (s_reg.pwr_cnt >= 24'(POWER_ON_CYC - 1))
          s_next.st = IDLE;
        else
          s_next.pwr_cnt = s_reg.pwr_cnt + 24'h000001;
      end
      IDLE:
      begin
        if (req_valid)
        begin
          s_next.r = req;
          s_next.step = 3'd0;
          s_next.nsteps = seq_len(req.op);
          s_next.err = 1'b0;
          s_next.have_last = 1'b0;
          s_next.poll_cnt = '0;
          s_next.st = WRITE;
          if ((req.op == flash_ctl_pkg::OP_PROGRAM || req.op == flash_ctl_pkg::OP_SECTOR_ERASE)
              && is_boot(req.addr) && s_reg.locked && !req.override)
          begin
            s_next.err = 1'b1;
            s_next.st = REPORT;
          end
        end
      end
      WRITE:
      begin
        if (!s_reg.go && !cyc_done && !s_next.go)
        begin
          s_next.go = 1'b1;
          s_next.wr = (s_reg.r.op != flash_ctl_pkg::OP_READ);
          s_next.a = (s_reg.r.op == flash_ctl_pkg::OP_READ) ? s_reg.r.addr : sw[34:16];
          s_next.d = sw[15:0];
        end
        if (cyc_done)
        begin
          s_next.go = 1'b0;
          s_next.data = cyc_rdata;
          if (s_reg.step + 3'd1 < s_reg.nsteps)
            s_next.step = s_reg.step + 3'd1;
          else if (s_reg.r.op == flash_ctl_pkg::OP_PROGRAM
                   || s_reg.r.op == flash_ctl_pkg::OP_SECTOR_ERASE
                   || s_reg.r.op == flash_ctl_pkg::OP_CHIP_ERASE)
            s_next.st = POLL;
          else
          begin
            if (s_reg.r.op == flash_ctl_pkg::OP_LOCKOUT)
              s_next.locked = 1'b1;
            s_next.st = REPORT;
          end
        end
        else if (s_reg.go)
          s_next.go = 1'b0;
      end
      POLL:
      begin
        // no command writes while busy, reads only
        if (!s_reg.go && !cyc_done)
        begin
          s_next.go = 1'b1;
          s_next.wr = 1'b0;
          s_next.a = s_reg.r.addr;
        end
        if (cyc_done)
        begin
          s_next.go = 1'b0;
          s_next.last_rd = cyc_rdata;
          s_next.have_last = 1'b1;
          s_next.poll_cnt = s_reg.poll_cnt + 20'h00001;
          s_next.data = cyc_rdata;
          // done when bit 6 stops toggling
          if (s_reg.have_last && flash_ready_n_low
              && cyc_rdata[flash_ctl_pkg::TOGGLE_BIT] == s_reg.last_rd[flash_ctl_pkg::TOGGLE_BIT])
          begin
            s_next.st = REPORT;
            // true data on bit 7 after completion
            // a zero bit that should be one means a failed program
            if (s_reg.r.op == flash_ctl_pkg::OP_PROGRAM)
              s_next.err = (cyc_rdata != s_reg.r.data);
            else
              s_next.err = ~cyc_rdata[flash_ctl_pkg::POLL_BIT];
          end
          else if (s_reg.poll_cnt >= 20'(POLL_LIMIT - 1))
          begin
            s_next.err = 1'b1;
            s_next.st = REPORT;
          end
        end
      end
      REPORT:
      begin
        s_next.valid = 1'b1;
        s_next.st = IDLE;
        // bit 0 at the status location shows lockout
        if (s_reg.r.op == flash_ctl_pkg::OP_READ
            && s_reg.r.addr == (TOP_BOOT ? flash_ctl_pkg::LOCK_STAT_TOP
                                         : flash_ctl_pkg::LOCK_STAT_BOTTOM))
          s_next.locked = s_reg.data[flash_ctl_pkg::LOCK_BIT];
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.st <= WAIT_PWR;
    end
    else
      s_reg <= s_next;
  end

  // only boot-block targets are checked against lockout
  assign req_ready = (s_reg.st == IDLE);
  assign resp_valid = s_reg.valid;
  assign resp_data = s_reg.data;
  assign resp_error = s_reg.err;
  assign resp_locked = s_reg.locked;
  // strobes from the cycle engine, OE high on writes
  assign flash_addr = pins.addr;
  assign flash_dq_out = pins.dout;
  assign flash_dq_oe_n = pins.dq_oe_n;
  assign flash_ce_n = pins.ce_n;
  assign flash_oe_n = pins.oe_n;
  assign flash_we_n = pins.we_n;
  // host reset mid-program corrupts that word
  assign flash_reset_n = rst_n;
  // override held for the whole operation
  assign flash_override = s_reg.r.override && (s_reg.st == WRITE || s_reg.st == POLL);
endmodule
`default_nettype wire

// ===== flash_ctl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module flash_ctl_sva #(
  parameter int POWER_ON_CYC = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic [18:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n
);
  int up_reg;
  // Saturates so a long run cannot wrap it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      up_reg <= 0;
    else if (up_reg < POWER_ON_CYC)
      up_reg <= up_reg + 1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_power_hold: assert property (req_ready |-> up_reg >= POWER_ON_CYC - 1)
    else $error("request taken before power-on delay");
  a_strobe_excl: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and read strobes low together");
  a_ce_frames: assert property (!flash_we_n || !flash_oe_n |-> !flash_ce_n)
    else $error("strobe low without chip select");
  a_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n)
    else $error("write strobe width wrong");
  a_addr_steady: assert property (!flash_we_n |-> $stable(flash_addr))
    else $error("address moved under write strobe");
  a_data_hold: assert property ($rose(flash_we_n) |-> $stable(flash_dq_out) && !flash_dq_oe_n
    && !flash_ce_n)
    else $error("data not held at strobe rise");
  a_read_float: assert property (!flash_oe_n |-> flash_dq_oe_n)
    else $error("host drives data during read");
  a_write_drive: assert property (!flash_we_n |-> !flash_dq_oe_n)
    else $error("host not driving data during write");
  a_resp_pulse: assert property (resp_valid |=> !resp_valid && !$stable(resp_valid))
    else $error("response longer than one cycle");
  c_write: cover property ($fell(flash_we_n));
  c_read: cover property ($fell(flash_oe_n));
  c_resp: cover property (resp_valid);
endmodule
`default_nettype wire

// ===== flash_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter int BUSY_NS = 1000
) (
  input wire logic [18:0] addr,
  input wire logic [15:0] dq,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic override,
  output logic [15:0] dq_in,
  output logic ready_n_low
);
  logic [15:0] mem [int];
  logic [15:0] last_d = 16'h0000;
  int step = 0;
  bit locked = 0;
  bit id_mode = 0;
  bit busy = 0;
  bit erasing = 0;
  bit tog = 0;
  realtime t_fall = 0;
  assign ready_n_low = !busy;
  initial dq_in = 16'h0000;
  function automatic logic [15:0] rd(int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  task automatic run(bit er, int lo, int hi, logic [15:0] d);
    if (lo < 32'h2000 && locked && !override)
      return;
    busy = 1;
    erasing = er;
    #(BUSY_NS);
    if (!er)
      mem[lo] = rd(lo) & d;
    else
      for (int k = lo; k <= hi; k++)
        mem.delete(k);
    busy = 0;
  endtask
  always @(negedge we_n)
    t_fall = $realtime;
  always @(posedge we_n)
  begin : wr
    logic [7:0] d;
    bit a5;
    bit a2;
    int lo;
    int hi;
    d = dq[7:0];
    a5 = addr[15:0] == 16'h5555;
    a2 = addr[15:0] == 16'h2AAA;
    lo = addr[18:12] == 7'h7F ? 32'h4000 : addr[18:12] == 7'h01 ? 0 : {addr[13:12], 12'h000};
    hi = addr[18:12] == 7'h7F ? 32'h7FFFF : addr[18:12] == 7'h01 ? 32'h1FFF : lo + 32'hFFF;
    if (ce_n === 1'b0 && oe_n === 1'b1 && !busy && $realtime - t_fall >= 15)
    begin
      if ((step == 0 || (step == 2 && a5)) && d == 8'hF0)
        id_mode = 0;
      if (step == 2 && a5 && d == 8'h90)
        id_mode = 1;
      if (step == 3)
      begin
        last_d = dq;
        fork
          run(0, addr, addr, dq);
        join_none
      end
      if (step == 6 && a5 && d == 8'h40)
        locked = 1;
      if (step == 6 && d == 8'h30)
        fork
          run(1, lo, hi, 16'h0000);
        join_none
      if (step == 6 && a5 && d == 8'h10)
        fork
          run(1, locked && !override ? 32'h2000 : 0, 32'h7FFFF, 16'h0000);
        join_none
      case (step)
        0: step = (a5 && d == 8'hAA) ? 1 : 0;
        1: step = (a2 && d == 8'h55) ? 2 : 0;
        2: step = !a5 ? 0 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
        4: step = (a5 && d == 8'hAA) ? 5 : 0;
        5: step = (a2 && d == 8'h55) ? 6 : 0;
        default: step = 0;
      endcase
    end
  end
  always @(negedge oe_n)
  begin
    if (ce_n === 1'b0)
    begin
      tog = !tog;
      if (busy)
        dq_in = {last_d[15:8], erasing ? 1'b0 : !last_d[7], tog, last_d[5:0]};
      else if (id_mode && addr == 19'h00002)
        dq_in = {15'h0000, locked};
      else
        dq_in = rd(addr);
    end
  end
  // Released lines must not keep the last read value
  always @(posedge oe_n)
    dq_in = ~dq_in;
endmodule
`default_nettype wire

// ===== parallel_flash_program_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module parallel_flash_program_control_test;
  localparam int POWER_ON_CYC = 10;
  logic clk = 0;
  logic rst_n = 0;
  logic req_valid = 0;
  flash_ctl_pkg::req_type req = '0;
  logic req_ready;
  logic resp_valid;
  logic [15:0] resp_data;
  logic resp_error;
  logic resp_locked;
  logic [18:0] flash_addr;
  logic [15:0] flash_dq_out;
  logic flash_dq_oe_n;
  logic flash_ce_n;
  logic flash_oe_n;
  logic flash_we_n;
  logic flash_override;
  logic dev_rst_n;
  logic rdy_line;
  logic [15:0] dev_dq;
  logic [15:0] bus;
  logic [15:0] bmem [int];
  bit block = 0;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int a;
  logic [15:0] v;
  flash_ctl_pkg::op_type ex [2] = '{flash_ctl_pkg::OP_ID_EXIT, flash_ctl_pkg::OP_ID_EXIT_SHORT};
  assign bus = !flash_dq_oe_n ? flash_dq_out : dev_dq;
  always #10 clk = !clk;
  flash_host_ctl #(.POWER_ON_CYC(POWER_ON_CYC), .POLL_LIMIT(50), .TOP_BOOT(1'b0)) i_dut (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_error(resp_error),
    .resp_locked(resp_locked), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(bus), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_reset_n(dev_rst_n),
    .flash_override(flash_override), .flash_ready_n_low(rdy_line));
  flash_dev_model i_dev (.addr(flash_addr), .dq(bus), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .override(flash_override), .dq_in(dev_dq), .ready_n_low(rdy_line));
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] ev(int k);
    return bmem.exists(k) ? bmem[k] : 16'hFFFF;
  endfunction
  task automatic do_req(flash_ctl_pkg::op_type op, int ad, logic [15:0] d, logic ov);
    @(posedge clk);
    req <= '{op, ad[18:0], d, ov};
    req_valid <= 1'b1;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    do @(negedge clk); while (resp_valid !== 1'b1);
  endtask
  task automatic prog(int ad, logic [15:0] d, bit ov);
    bit refuse;
    bit fail;
    refuse = ad < 32'h2000 && block && !ov;
    // Ones cannot be programmed back, so such a word reads back as failed
    fail = refuse || ((ev(ad) & d) != d);
    do_req(flash_ctl_pkg::OP_PROGRAM, ad, d, ov);
    chk("program error", resp_error, fail);
    if (!refuse)
      bmem[ad] = ev(ad) & d;
    do_req(flash_ctl_pkg::OP_READ, ad, 16'h0000, 1'b0);
    chk("read back", resp_data, ev(ad));
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    void'($urandom(32'h2D74404C));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(negedge clk);
    chk("ready early", req_ready, 1'b0);
    chk("reset pin", dev_rst_n, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      a = 32'h40000 + ($urandom & 32'hFFFF);
      prog(a, 16'($urandom), 0);
      prog(a, 16'($urandom), 0);
    end
    prog(32'h00100, 16'($urandom), 0);
    $display("test program done");
    do_req(flash_ctl_pkg::OP_SECTOR_ERASE, flash_ctl_pkg::SECT_BOTTOM_MAIN, 16'h0000, 1'b0);
    chk("erase error", resp_error, 1'b0);
    v = ev(32'h00100);
    bmem.delete();
    bmem[32'h00100] = v;
    do_req(flash_ctl_pkg::OP_READ, a, 16'h0000, 1'b0);
    chk("erased word", resp_data, 16'hFFFF);
    do_req(flash_ctl_pkg::OP_READ, 32'h00100, 16'h0000, 1'b0);
    chk("boot kept", resp_data, v);
    $display("test erase done");
    do_req(flash_ctl_pkg::OP_LOCKOUT, 32'h05555, 16'h0000, 1'b0);
    block = 1;
    chk("locked", resp_locked, 1'b1);
    prog(32'h00200, 16'($urandom), 0);
    a = 32'h50000 + ($urandom & 32'hFF);
    prog(a, 16'($urandom), 0);
    prog(32'h00300, 16'($urandom), 1);
    // Chip erase clears the main array but must spare the locked boot block
    do_req(flash_ctl_pkg::OP_CHIP_ERASE, 32'h05555, 16'h0000, 1'b0);
    chk("chip erase error", resp_error, 1'b0);
    bmem.delete(a);
    do_req(flash_ctl_pkg::OP_READ, a, 16'h0000, 1'b0);
    chk("chip erased word", resp_data, ev(a));
    do_req(flash_ctl_pkg::OP_READ, 32'h00100, 16'h0000, 1'b0);
    chk("boot after chip erase", resp_data, v);
    $display("test lockout done");
    foreach (ex[j])
    begin
      do_req(flash_ctl_pkg::OP_ID_ENTRY, 32'h05555, 16'h0000, 1'b0);
      do_req(flash_ctl_pkg::OP_READ, flash_ctl_pkg::LOCK_STAT_BOTTOM, 16'h0000, 1'b0);
      chk("lock bit", resp_data[0], 1'b1);
      // The single-write exit may go to any address
      a = (j == 0) ? 32'h05555 : 32'h40000 + ($urandom & 32'hFFFF);
      do_req(ex[j], a, 16'h0000, 1'b0);
      do_req(flash_ctl_pkg::OP_READ, 32'h00002, 16'h0000, 1'b0);
      chk("after exit", resp_data, ev(32'h00002));
    end
    $display("test ident done");
    report_and_stop();
  end
endmodule
bind flash_host_ctl flash_ctl_sva #(.POWER_ON_CYC(POWER_ON_CYC)) i_sva (
  .clk(clk), .rst_n(rst_n), .req_ready(req_ready), .resp_valid(resp_valid),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
`default_nettype wire
